//--- rtl/uc_fifo_uart_ctl.sv
/*
  FIFO-mode control, interrupt and DMA request logic of a serial
  transceiver, with its register file on AXI4-Lite.
  Assumes the shift logic supplies received bytes, one tick per
  character time, and drains the transmit FIFO.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
// Operation
// - Reset state matches legacy non-FIFO register behaviour.
// - FIFOs stay disabled until software enables them.
// - Idle delay raises receive interrupt below trigger.
// - Provide receive and transmit DMA request outputs.
// - Enable register low four bits enable sources.
// - Modem control bit 3 drives auxiliary output.
// - Interrupt output is a level, not pulse.
// - Interrupt stays high while any enabled source is pending.
// - Divisor access bit redirects shared addresses.
// - Line control selects bits, stops and parity.
// - FIFO control bits 7:6 select trigger level.
// - FIFO control bits 5:4 have no effect.
// - FIFO control bit 3 selects DMA mode.
// - Bits 2 and 1 clear transmit, receive FIFO.
// - Enabling FIFOs clears both FIFOs automatically.
// - Identification bits 7:6 read ones in FIFO mode.
// - Status reads clear line and modem indications.
// - Trigger levels 1,4,8,14; FIFO holds sixteen.
// - Timeout after four idle character times.
// - Single mode: requests follow empty state.
// - Multi mode: receive on trigger or timeout until empty; transmit until full.
module uc_fifo_uart_ctl
  import uc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register bus
  input wire uc_axi_req_s axiReq,
  output uc_axi_rsp_s axiRsp,
  // Receiver side
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic [2:0] rxLineErr,
  input wire logic charTick,
  // Transmitter side
  output logic txCharValid,
  output logic [7:0] txChar,
  input wire logic txCharTake,
  input wire logic txShiftBusy,
  // Modem lines
  input wire logic [3:0] modemLines,
  input wire logic [3:0] modemDelta,
  // Configuration to the serial logic
  output logic [15:0] divisor,
  output logic [6:0] lineControl,
  output logic [4:0] modemControl,
  // System outputs
  output logic auxOutputTwo,
  output logic irqOutput,
  output logic rxDmaRequest,
  output logic txDmaRequest
);
  typedef struct packed {
    logic awHave;
    logic [ADDR_W-1:0] awAddr;
    logic wHave;
    logic [7:0] wData;
    logic wStrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rData;
    logic [1:0] rresp;
    logic [3:0] ier;
    logic [7:0] lcr;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic [15:0] div;
    logic fifoEn;
    logic dmaMode;
    logic [1:0] trig;
    logic overrun;
    logic [2:0] lineErr;
    logic [3:0] delta;
    logic threPend;
    logic txWasEmpty;
    logic [2:0] tmoCnt;
    logic tmoPend;
    logic rxHold;
    logic rxReq;
    logic txReq;
    logic irq;
  } uc_ctl_state_s;
  uc_ctl_state_s s_q, n;

  logic awTake, wTake, arTake, doWrite, wrMapped, rdMapped, wrEn, divisor_access_bit;
  logic [2:0] wrIdx, rdIdx;
  logic thrWr, ierWr, fcWr, mcrWr, rbrRd, iirRd, lsrRd, msrRd;
  logic fifoSwitch, rxFlush, txFlush, rxPop, txPop, rxOvfSet;
  logic rxFull, rxEmpty, txFull, txEmpty, dmaMulti, rxDataPend, linePend;
  logic [CNT_W-1:0] rxCount, txCount;
  logic [7:0] rxHead, rdVal, iirVal, lsrVal;
  logic [4:0] trigLevel;
  logic [3:0] iirCode;

  // Bus handshakes; one write and one read outstanding at a time
  assign axiRsp.awready = !s_q.awHave && !s_q.bvalid;
  assign axiRsp.wready = !s_q.wHave && !s_q.bvalid;
  assign axiRsp.arready = !s_q.rvalid;
  assign axiRsp.bvalid = s_q.bvalid;
  assign axiRsp.bresp = s_q.bresp;
  assign axiRsp.rvalid = s_q.rvalid;
  assign axiRsp.rdata = {24'h000000, s_q.rData};
  assign axiRsp.rresp = s_q.rresp;
  assign awTake = axiReq.awvalid && axiRsp.awready;
  assign wTake = axiReq.wvalid && axiRsp.wready;
  assign arTake = axiReq.arvalid && axiRsp.arready;
  assign doWrite = s_q.awHave && s_q.wHave;
  assign wrIdx = s_q.awAddr[4:2];
  assign rdIdx = axiReq.araddr[4:2];
  assign wrMapped = (s_q.awAddr[ADDR_W-1:5] == '0);
  assign rdMapped = (axiReq.araddr[ADDR_W-1:5] == '0);
  // Only byte lane 0 carries register data
  assign wrEn = doWrite && wrMapped && s_q.wStrb0;
  assign divisor_access_bit = s_q.lcr[DIVISOR_ACCESS_BIT];

  // Register decode; the divisor bytes hide data and enables
  assign thrWr = wrEn && (wrIdx == IDX_DATA) && !divisor_access_bit;
  assign ierWr = wrEn && (wrIdx == IDX_INT_ENABLE) && !divisor_access_bit;
  assign fcWr = wrEn && (wrIdx == IDX_FIFO_CONTROL);
  assign mcrWr = wrEn && (wrIdx == IDX_MODEM_CONTROL);
  assign rbrRd = arTake && rdMapped && (rdIdx == IDX_DATA) && !divisor_access_bit;
  assign iirRd = arTake && rdMapped && (rdIdx == IDX_FIFO_CONTROL);
  assign lsrRd = arTake && rdMapped && (rdIdx == IDX_LINE_STATUS);
  assign msrRd = arTake && rdMapped && (rdIdx == IDX_MODEM_STATUS);

  // Mode change flushes both; clear bits act only with bit 0 set
  assign fifoSwitch = fcWr &&
    (s_q.wData[FIFO_ENABLE_BIT] != s_q.fifoEn);
  assign rxFlush = fifoSwitch || (fcWr && s_q.wData[FIFO_ENABLE_BIT] &&
    s_q.wData[RX_CLEAR_BIT]);
  assign txFlush = fifoSwitch || (fcWr && s_q.wData[FIFO_ENABLE_BIT] &&
    s_q.wData[TX_CLEAR_BIT]);
  assign rxPop = rbrRd;
  assign txPop = txCharTake;
  assign rxOvfSet = rxCharValid && rxFull && !(rxPop && !rxEmpty);

  // Disabled FIFOs act as one-byte holding registers
  uc_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(rxFlush),
    .oneDeep(!s_q.fifoEn),
    .push(rxCharValid),
    .pushData(rxChar),
    .pop(rxPop),
    .popData(rxHead),
    .count(rxCount),
    .full(rxFull),
    .empty(rxEmpty)
  );

  uc_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(txFlush),
    .oneDeep(!s_q.fifoEn),
    .push(thrWr),
    .pushData(s_q.wData),
    .pop(txPop),
    .popData(txChar),
    .count(txCount),
    .full(txFull),
    .empty(txEmpty)
  );

  always_comb begin
    unique case (s_q.trig)
      2'h0: trigLevel = TRIG_LEVEL_0;
      2'h1: trigLevel = TRIG_LEVEL_1;
      2'h2: trigLevel = TRIG_LEVEL_2;
      2'h3: trigLevel = TRIG_LEVEL_3;
    endcase
  end

  assign dmaMulti = s_q.fifoEn && s_q.dmaMode;
  assign rxDataPend = s_q.fifoEn ? (rxCount >= trigLevel) : !rxEmpty;
  assign linePend = s_q.overrun || (s_q.lineErr != '0);

  // Highest priority source among the enabled ones
  always_comb begin
    if (s_q.ier[IE_LINE_BIT] && linePend) begin
      iirCode = ID_LINE;
    end else if (s_q.ier[IE_RX_BIT] && rxDataPend) begin
      iirCode = ID_RX_DATA;
    end else if (s_q.ier[IE_RX_BIT] && s_q.tmoPend) begin
      iirCode = ID_TIMEOUT;
    end else if (s_q.ier[IE_THRE_BIT] && s_q.threPend) begin
      iirCode = ID_THRE;
    end else if (s_q.ier[IE_MODEM_BIT] && (s_q.delta != '0)) begin
      iirCode = ID_MODEM;
    end else begin
      iirCode = ID_NONE;
    end
    iirVal = {(s_q.fifoEn ? ID_FIFO_MARK : 2'h0), 2'h0, iirCode};
  end

  assign lsrVal = {s_q.fifoEn && (s_q.lineErr != '0),
    txEmpty && !txShiftBusy, txEmpty, s_q.lineErr, s_q.overrun, !rxEmpty};

  always_comb begin
    unique case (rdIdx)
      IDX_DATA: rdVal = divisor_access_bit ? s_q.div[7:0] : rxHead;
      IDX_INT_ENABLE: rdVal = divisor_access_bit ? s_q.div[15:8] : {4'h0, s_q.ier};
      IDX_FIFO_CONTROL: rdVal = iirVal;
      IDX_LINE_CONTROL: rdVal = s_q.lcr;
      IDX_MODEM_CONTROL: rdVal = {3'h0, s_q.mcr};
      IDX_LINE_STATUS: rdVal = lsrVal;
      IDX_MODEM_STATUS: rdVal = {modemLines, s_q.delta};
      IDX_SCRATCH: rdVal = s_q.scr;
    endcase
  end

  always_comb begin
    n = s_q;
    // Write channel
    if (awTake) begin
      n.awHave = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (wTake) begin
      n.wHave = 1'b1;
      n.wData = axiReq.wdata[7:0];
      n.wStrb0 = axiReq.wstrb[0];
    end
    if (doWrite) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.bvalid && axiReq.bready) begin
      n.bvalid = 1'b0;
    end
    // Read channel; data is captured when the address is taken
    if (arTake) begin
      n.rvalid = 1'b1;
      n.rData = rdMapped ? rdVal : 8'h00;
      n.rresp = rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && axiReq.rready) begin
      n.rvalid = 1'b0;
    end
    // Plain registers
    if (ierWr) begin
      n.ier = s_q.wData[3:0];
    end
    if (wrEn && divisor_access_bit && (wrIdx == IDX_DATA)) begin
      n.div[7:0] = s_q.wData;
    end
    if (wrEn && divisor_access_bit && (wrIdx == IDX_INT_ENABLE)) begin
      n.div[15:8] = s_q.wData;
    end
    if (wrEn && (wrIdx == IDX_LINE_CONTROL)) begin
      n.lcr = s_q.wData;
    end
    if (mcrWr) begin
      n.mcr = s_q.wData[4:0];
    end
    if (wrEn && (wrIdx == IDX_SCRATCH)) begin
      n.scr = s_q.wData;
    end
    // Other bits change only while bit 0 is written set; 5:4 unused
    if (fcWr) begin
      n.fifoEn = s_q.wData[FIFO_ENABLE_BIT];
      if (s_q.wData[FIFO_ENABLE_BIT]) begin
        n.dmaMode = s_q.wData[DMA_MODE_BIT];
        n.trig = s_q.wData[TRIGGER_LSB +: 2];
      end
    end
    // Status reads clear, but a new event in the same cycle wins
    if (lsrRd) begin
      n.overrun = 1'b0;
      n.lineErr = 3'h0;
    end
    if (rxOvfSet) begin
      n.overrun = 1'b1;
    end
    if (rxCharValid && !rxOvfSet) begin
      n.lineErr = n.lineErr | rxLineErr;
    end
    if (msrRd) begin
      n.delta = 4'h0;
    end
    n.delta = n.delta | modemDelta;
    // Transmit empty indication: cleared by a write or by reading it
    if (thrWr || (iirRd && (iirCode == ID_THRE))) begin
      n.threPend = 1'b0;
    end
    if ((txEmpty && !s_q.txWasEmpty) || (ierWr && txEmpty &&
        s_q.wData[IE_THRE_BIT] && !s_q.ier[IE_THRE_BIT])) begin
      n.threPend = 1'b1;
    end
    n.txWasEmpty = txEmpty;
    // Idle timeout; any access to the receive FIFO restarts it
    if (!s_q.fifoEn || rxEmpty || rxCharValid || rxPop || rxFlush) begin
      n.tmoCnt = 3'h0;
      n.tmoPend = 1'b0;
    end else if (charTick && !s_q.tmoPend) begin
      if (s_q.tmoCnt == TIMEOUT_LAST) begin
        n.tmoCnt = 3'h0;
        n.tmoPend = 1'b1;
      end else begin
        n.tmoCnt = s_q.tmoCnt + 3'h1;
      end
    end
    // Multi-transfer receive request holds until the FIFO drains
    if (rxEmpty) begin
      n.rxHold = 1'b0;
    end else if (rxDataPend || s_q.tmoPend) begin
      n.rxHold = 1'b1;
    end
    n.rxReq = dmaMulti ? n.rxHold : !rxEmpty;
    n.txReq = dmaMulti ? !txFull : txEmpty;
    // Level output; an edge controller needs from the host
    n.irq = (iirCode != ID_NONE);
  end

  // All-zero reset gives the legacy non-FIFO register state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= n;
    end
  end

  assign txCharValid = !txEmpty;
  assign divisor = s_q.div;
  assign lineControl = s_q.lcr[6:0];
  assign modemControl = s_q.mcr;
  assign auxOutputTwo = s_q.mcr[AUX_OUTPUT_TWO_BIT];
  assign irqOutput = s_q.irq;
  assign rxDmaRequest = s_q.rxReq;
  assign txDmaRequest = s_q.txReq;

  a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
    (iirCode != ID_NONE) |=> irqOutput)
    else $error("interrupt level missing while a source is pending");
  a_irq_held: assert property (@(posedge clock) disable iff (!resetn)
    irqOutput && (iirCode != ID_NONE) |=> irqOutput && !$fell(irqOutput))
    else $error("interrupt output dropped while still pending");
  a_fifo_stay_off: assert property (@(posedge clock) disable iff (!resetn)
    !s_q.fifoEn && !fcWr |=> !s_q.fifoEn)
    else $error("FIFOs enabled without a control write");
  a_enable_clears: assert property (@(posedge clock) disable iff (!resetn)
    fcWr && s_q.wData[0] && !s_q.fifoEn |-> rxFlush && txFlush
    ##1 rxEmpty && txEmpty)
    else $error("enabling FIFOs did not clear them");
  a_fifo_mark: assert property (@(posedge clock) disable iff (!resetn)
    iirRd && s_q.fifoEn |=> axiRsp.rdata[7:6] == 2'h3)
    else $error("identification bits not set in FIFO mode");
  a_divisor_route: assert property (@(posedge clock) disable iff (!resetn)
    arTake && rdMapped && rdIdx == IDX_DATA && divisor_access_bit
    |=> axiRsp.rdata[7:0] == $past(s_q.div[7:0]))
    else $error("divisor low byte not returned under access bit");
  a_timeout_fire: assert property (@(posedge clock) disable iff (!resetn)
    s_q.fifoEn && !rxEmpty && charTick && s_q.tmoCnt == TIMEOUT_LAST &&
    !rxCharValid && !rxPop && !rxFlush |=> s_q.tmoPend)
    else $error("receive timeout did not fire after four ticks");
  a_single_dma: assert property (@(posedge clock) disable iff (!resetn)
    !dmaMulti |=> rxDmaRequest == !$past(rxEmpty) &&
    txDmaRequest == $past(txEmpty))
    else $error("single-transfer DMA requests wrong");
  a_multi_tx_dma: assert property (@(posedge clock) disable iff (!resetn)
    dmaMulti |=> txDmaRequest == !$past(txFull))
    else $error("multi-transfer transmit request wrong");
  a_trigger_max: assert property (@(posedge clock) disable iff (!resetn)
    s_q.fifoEn && s_q.trig == 2'h3 && rxCount == 5'h0E && !s_q.tmoPend
    |-> rxDataPend)
    else $error("fourteen bytes did not reach the top trigger");
  a_aux_follow: assert property (@(posedge clock) disable iff (!resetn)
    mcrWr |=> auxOutputTwo == $past(s_q.wData[3]))
    else $error("auxiliary output did not follow modem control");
  a_status_clear: assert property (@(posedge clock) disable iff (!resetn)
    lsrRd && !rxOvfSet && !rxCharValid |=> !s_q.overrun &&
    s_q.lineErr == 3'h0)
    else $error("line status read did not clear indications");
  a_dma_mode_zero: assert property (@(posedge clock) disable iff (!resetn)
    fcWr && s_q.wData[0] && !s_q.wData[3] |=> !dmaMulti)
    else $error("DMA mode bit zero did not select mode 0");
  a_enable_all: assert property (@(posedge clock) disable iff (!resetn)
    ierWr && s_q.wData[3:0] == 4'hF |=> s_q.ier == 4'hF)
    else $error("writing 0F did not enable all sources");

  c_fifo_on: cover property (@(posedge clock) disable iff (!resetn)
    $rose(s_q.fifoEn));
  c_timeout: cover property (@(posedge clock) disable iff (!resetn)
    $rose(s_q.tmoPend));
  c_multi_rx: cover property (@(posedge clock) disable iff (!resetn)
    dmaMulti && $rose(rxDmaRequest));
  c_irq_rise: cover property (@(posedge clock) disable iff (!resetn)
    $rose(irqOutput));
endmodule // uc_fifo_uart_ctl
`default_nettype wire

//--- rtl/uc_pkg.sv
/*
  Constants and carrier types for the FIFO serial controller.
  Assumes an AXI4-Lite master with 32-bit data; one register per word.
*/
`default_nettype none
package uc_pkg;
  // Bus
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
  localparam logic [2:0] IDX_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] IDX_LINE_CONTROL = 3'h3;
  localparam logic [2:0] IDX_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] IDX_LINE_STATUS = 3'h5;
  localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
  localparam logic [2:0] IDX_SCRATCH = 3'h7;
  // Field positions
  localparam int unsigned FIFO_ENABLE_BIT = 0;
  localparam int unsigned RX_CLEAR_BIT = 1;
  localparam int unsigned TX_CLEAR_BIT = 2;
  localparam int unsigned DMA_MODE_BIT = 3;
  localparam int unsigned TRIGGER_LSB = 6;
  localparam int unsigned DIVISOR_ACCESS_BIT = 7;
  localparam int unsigned AUX_OUTPUT_TWO_BIT = 3;
  localparam int unsigned IE_RX_BIT = 0;
  localparam int unsigned IE_THRE_BIT = 1;
  localparam int unsigned IE_LINE_BIT = 2;
  localparam int unsigned IE_MODEM_BIT = 3;
  // Reset value of every control register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Interrupt identification codes, low nibble
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  localparam logic [3:0] ID_THRE = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;
  localparam logic [1:0] ID_FIFO_MARK = 2'h3;
  // FIFO sizing and receive trigger levels
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
  localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
  localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
  localparam logic [4:0] TRIG_LEVEL_3 = 5'h0E;
  // Receive idle timeout in character times
  localparam int unsigned TIMEOUT_CHARS = 4;
  localparam logic [2:0] TIMEOUT_LAST = 3'(TIMEOUT_CHARS - 1);

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } uc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uc_axi_rsp_s;
endpackage
`default_nettype wire

//--- rtl/uc_byte_fifo.sv
/*
  Small synchronous FIFO with flush and a one-entry mode.
  Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`default_nettype none
module uc_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned CW = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic flush,
  input wire logic oneDeep,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] popData,
  // Level
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } uc_fifo_state_s;
  uc_fifo_state_s s_q, s_d;
  logic doPush, doPop;

  // One-entry mode behaves like a plain holding register
  assign full = oneDeep ? (s_q.cnt != '0) : (s_q.cnt == CW'(DEPTH));
  assign empty = (s_q.cnt == '0);
  assign count = s_q.cnt;
  assign popData = s_q.mem[s_q.rp];
  assign doPop = pop && !empty;
  assign doPush = push && (!full || doPop);

  always_comb begin
    s_d = s_q;
    if (flush) begin
      // Flush wins over a push in the same cycle
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end else begin
      if (doPush) begin
        s_d.mem[s_q.wp] = pushData;
        s_d.wp = s_q.wp + 1'b1;
      end
      if (doPop) begin
        s_d.rp = s_q.rp + 1'b1;
      end
      if (doPush && !doPop) begin
        s_d.cnt = s_q.cnt + 1'b1;
      end else if (doPop && !doPush) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // uc_byte_fifo
`default_nettype wire

//--- dv/uc_serial_model.sv
/*
  Serial-side partner: character ticks, bytes received on request and
  a transmitter that drains one byte per character time.
  Assumes the bench kicks receptions and may stall the transmitter.
*/
`default_nettype none
module uc_serial_model #(
  parameter int unsigned TICK = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Bench control
  input wire logic rxKick,
  input wire logic txStall,
  // Block side
  output logic rxCharValid,
  output logic [7:0] rxChar,
  output logic charTick,
  input wire logic txCharValid,
  output logic txCharTake
);
  logic [7:0] div;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div <= 8'h00;
      charTick <= 1'b0;
      rxCharValid <= 1'b0;
      rxChar <= 8'hA0;
      txCharTake <= 1'b0;
    end else begin
      charTick <= div == 8'(TICK - 1);
      div <= (div == 8'(TICK - 1)) ? 8'h00 : div + 8'h01;
      rxCharValid <= rxKick;
      // Step past a taken byte so a stale value never looks valid
      if (rxCharValid) rxChar <= rxChar + 8'h01;
      txCharTake <= txCharValid && charTick && !txStall;
    end
  end
endmodule  // uc_serial_model
`default_nettype wire

//--- dv/uc_fifo_uart_ctl_tb.sv
/*
  Self-checking bench: AXI4-Lite register tasks and directed tests.
  Assumes uc_serial_model stands in for the shift logic.
*/
`default_nettype none
module uc_fifo_uart_ctl_tb
  import uc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  uc_axi_req_s q;
  uc_axi_rsp_s r;
  logic clock, resetn, rxKick, txStall, rxCharValid, charTick, txTake;
  logic txValid, auxOutputTwo, irqOutput, rxDmaRequest, txDmaRequest;
  logic [7:0] rxChar, rdv, txChar;
  logic [4:0] modemControl;
  logic [3:0] modemDelta;
  logic [15:0] divisor;
  logic [6:0] lineControl;
  logic [1:0] rsp, bsp;
  int badCount = 0;
  int nChecks = 0;
  uc_fifo_uart_ctl i_uc_fifo_uart_ctl (
    .clock(clock), .resetn(resetn), .axiReq(q), .axiRsp(r),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxLineErr(3'h0),
    .charTick(charTick), .txCharValid(txValid), .txChar(txChar),
    .txCharTake(txTake), .txShiftBusy(1'b0), .modemLines(4'h0),
    .modemDelta(modemDelta), .divisor(divisor),
    .lineControl(lineControl), .modemControl(modemControl),
    .auxOutputTwo(auxOutputTwo), .irqOutput(irqOutput),
    .rxDmaRequest(rxDmaRequest), .txDmaRequest(txDmaRequest));
  uc_serial_model i_uc_serial_model (
    .clock(clock), .resetn(resetn), .rxKick(rxKick), .txStall(txStall),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .charTick(charTick),
    .txCharValid(txValid), .txCharTake(txTake));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [11:0] a(input logic [2:0] i);
    return {7'h00, i, 2'h0};
  endfunction
  task automatic finishTest();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      badCount++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ci(input int n, input logic e);
    cy(n);
    cb(irqOutput, e);
  endtask
  // Readies are sampled mid-cycle, where they have settled
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    logic ta, tw, da, dw, b;
    da = 1'b0;
    dw = 1'b0;
    b = 1'b0;
    @(posedge clock);
    q.awvalid <= 1'b1;
    q.awaddr <= ad;
    q.wvalid <= 1'b1;
    q.wdata <= {24'h000000, d};
    q.wstrb <= 4'h1;
    q.bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clock);
      ta = r.awready && !da;
      tw = r.wready && !dw;
      @(posedge clock);
      if (ta) q.awvalid <= 1'b0;
      if (tw) q.wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    while (!b) begin
      @(negedge clock);
      b = r.bvalid;
      bsp = r.bresp;
      @(posedge clock);
    end
    q.bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad);
    logic t;
    t = 1'b0;
    @(posedge clock);
    q.arvalid <= 1'b1;
    q.araddr <= ad;
    q.rready <= 1'b1;
    while (!t) begin
      @(negedge clock);
      t = r.arready;
      @(posedge clock);
    end
    q.arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clock);
      t = r.rvalid;
      rdv = r.rdata[7:0];
      rsp = r.rresp;
      @(posedge clock);
    end
    q.rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] ad, input logic [7:0] e);
    rd(ad);
    chk({24'h0, rdv}, {24'h0, e});
  endtask
  task automatic kick(input int n);
    repeat (n) begin
      @(posedge clock);
      rxKick <= 1'b1;
      @(posedge clock);
      rxKick <= 1'b0;
      repeat (2) @(posedge clock);
    end
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    finishTest();
  end
  initial begin
    q = '0;
    resetn = 1'b0;
    rxKick = 1'b0;
    txStall = 1'b1;
    modemDelta = 4'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    ci(2, 1'b0);
    cb(auxOutputTwo, 1'b0);
    cb(txDmaRequest, 1'b1);
    rc(a(IDX_FIFO_CONTROL), 8'h01);
    rc(a(IDX_INT_ENABLE), 8'h00);
    wr(a(IDX_LINE_CONTROL), 8'h80);
    wr(a(IDX_DATA), 8'h06);
    wr(a(IDX_INT_ENABLE), 8'h12);
    chk({16'h0, divisor}, 32'h1206);
    rc(a(IDX_DATA), 8'h06);
    wr(a(IDX_LINE_CONTROL), 8'h1A);
    chk({25'h0, lineControl}, 32'h1A);
    rc(a(IDX_INT_ENABLE), 8'h00);
    wr(a(IDX_INT_ENABLE), 8'h01);
    kick(1);
    ci(1, 1'b1);
    wr(a(IDX_FIFO_CONTROL), 8'hC1);
    ci(2, 1'b0);
    cb(rxDmaRequest, 1'b0);
    rc(a(IDX_FIFO_CONTROL), 8'hC1);
    kick(13);
    ci(1, 1'b0);
    cb(rxDmaRequest, 1'b1);
    kick(1);
    ci(1, 1'b1);
    rc(a(IDX_FIFO_CONTROL), 8'hC4);
    ci(8, 1'b1);
    wr(a(IDX_FIFO_CONTROL), 8'hC3);
    ci(2, 1'b0);
    cb(rxDmaRequest, 1'b0);
    kick(1);
    ci(1, 1'b0);
    ci(60, 1'b1);
    rc(a(IDX_FIFO_CONTROL), 8'hCC);
    rc(a(IDX_DATA), 8'hAF);
    ci(2, 1'b0);
    wr(a(IDX_FIFO_CONTROL), 8'h31);
    kick(1);
    ci(1, 1'b1);
    rc(a(IDX_FIFO_CONTROL), 8'hC4);
    rc(a(IDX_DATA), 8'hB0);
    wr(a(IDX_FIFO_CONTROL), 8'h49);
    kick(3);
    cb(rxDmaRequest, 1'b0);
    kick(1);
    cb(rxDmaRequest, 1'b1);
    wr(a(IDX_DATA), 8'h55);
    cy(1);
    cb(txDmaRequest, 1'b1);
    chk({24'h0, txChar}, 32'h55);
    wr(a(IDX_FIFO_CONTROL), 8'h41);
    cy(1);
    cb(txDmaRequest, 1'b0);
    @(posedge clock);
    txStall <= 1'b0;
    cy(30);
    cb(txDmaRequest, 1'b1);
    wr(a(IDX_INT_ENABLE), 8'h08);
    @(posedge clock);
    modemDelta <= 4'h1;
    @(posedge clock);
    modemDelta <= 4'h0;
    ci(2, 1'b1);
    rc(a(IDX_MODEM_STATUS), 8'h01);
    ci(2, 1'b0);
    wr(a(IDX_FIFO_CONTROL), 8'hC7);
    wr(a(IDX_INT_ENABLE), 8'h04);
    kick(16);
    ci(1, 1'b0);
    kick(1);
    ci(1, 1'b1);
    rd(a(IDX_LINE_STATUS));
    cb(rdv[1], 1'b1);
    ci(2, 1'b0);
    wr(a(IDX_FIFO_CONTROL), 8'hC7);
    wr(a(IDX_INT_ENABLE), 8'h0F);
    ci(2, 1'b1);
    rc(a(IDX_INT_ENABLE), 8'h0F);
    wr(a(IDX_INT_ENABLE), 8'h00);
    ci(1, 1'b0);
    wr(a(IDX_INT_ENABLE), 8'h0F);
    ci(1, 1'b1);
    wr(a(IDX_MODEM_CONTROL), 8'h08);
    cy(1);
    cb(auxOutputTwo, 1'b1);
    chk({27'h0, modemControl}, 32'h08);
    wr(12'h040, 8'h5A);
    chk({30'h0, bsp}, {30'h0, RESP_SLVERR});
    rd(12'h040);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rc(a(IDX_LINE_CONTROL), 8'h1A);
    finishTest();
  end
endmodule  // uc_fifo_uart_ctl_tb
`default_nettype wire
